// >>> core/ofc_top.v
// Output fallback control: holds one output word per channel, drives the
// converter code and an enable per channel, and applies the fallback states.
// Assumes switches and supply-good levels are asynchronous pins.
//
// The AHB-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/100ps
`include "ofc_consts.vh"

module ofc_top #(
  parameter UPDATE_CYC = `OFC_UPDATE_CYC
) (
  input  wire        clk,
  input  wire        resetn,
  input  wire        clk_en,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire [3:0]  fallback_select_switch,
  input  wire        logic_supply_ok,
  input  wire        io_bus_supply_ok,
  output reg  [47:0] dac_code,
  output reg  [3:0]  out_enable,
  output reg  [3:0]  update_tick
);

  // --------------------------------------------------------------
  // Reset release and pin synchronisers
  // --------------------------------------------------------------
  reg        rst_meta_reg;
  reg        rst_sync_reg;
  reg  [5:0] pin_meta_reg;
  reg  [5:0] pin_sync_reg;
  wire       rstn = rst_sync_reg;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_meta_reg <= 6'h00;
      pin_sync_reg <= 6'h00;
    end else if (clk_en) begin
      pin_meta_reg <= {io_bus_supply_ok, logic_supply_ok, fallback_select_switch};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  wire [3:0] sel_hold = pin_sync_reg[3:0];  // RULE1 RULE2
  wire       logic_ok = pin_sync_reg[4];
  wire       io_ok    = pin_sync_reg[5];

  // --------------------------------------------------------------
  // Word to converter code
  // --------------------------------------------------------------
  // Offset range drops bit 12, so 4096..8191 lands on 0..4095
  function [11:0] to_code;
    input [15:0] word;
    begin
      to_code = word[11:0];  // RULE9 RULE11
    end
  endfunction

  // --------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------
  // Channel words fill the first 16 bytes of the map
  function is_chan;
    input [11:0] addr;
    begin
      is_chan = (addr[11:4] == 8'h00);
    end
  endfunction

  function is_ctrl;
    input [11:0] addr;
    begin
      is_ctrl = (addr == `OFC_ADDR_CTRL);
    end
  endfunction

  // --------------------------------------------------------------
  // AHB-Lite slave
  // --------------------------------------------------------------
  reg  [15:0] word_reg [0:3];
  reg  [3:0]  valid_reg;
  reg         run_reg;
  reg         ran_reg;
  reg         wr_pend_reg;
  reg  [11:0] wr_addr_reg;
  reg  [31:0] rd_next;
  integer     i;
  integer     j;
  integer     k;

  wire        take  = hsel && hready && htrans == `OFC_HTRANS_NONSEQ;
  wire        wr_ch = wr_pend_reg && is_chan(wr_addr_reg);
  wire [1:0]  wr_ix = wr_addr_reg[3:2];

  // Read data is chosen in the address phase and stands from the next edge
  always @* begin
    rd_next = 32'h0000_0000;
    case (haddr[11:0])
      `OFC_ADDR_CH0:    rd_next = {16'h0000, word_reg[0]};
      `OFC_ADDR_CH1:    rd_next = {16'h0000, word_reg[1]};
      `OFC_ADDR_CH2:    rd_next = {16'h0000, word_reg[2]};
      `OFC_ADDR_CH3:    rd_next = {16'h0000, word_reg[3]};
      `OFC_ADDR_CTRL:   rd_next = {31'h0000_0000, run_reg};
      `OFC_ADDR_STATUS: rd_next = {20'h00000, out_enable, valid_reg,
                                   io_ok, logic_ok, ran_reg, sel_hold[0]};
      default:          rd_next = 32'h0000_0000;
    endcase
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
      hrdata      <= 32'h0000_0000;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      run_reg     <= 1'b0;
      ran_reg     <= 1'b0;
      valid_reg   <= 4'h0;
      for (i = 0; i < `OFC_NUM_CH; i = i + 1) begin
        word_reg[i] <= `OFC_WORD_RESET;
      end
    end else if (clk_en) begin
      wr_pend_reg <= take && hwrite;
      if (take) begin
        wr_addr_reg <= haddr[11:0];
      end
      if (take && !hwrite) begin
        hrdata <= rd_next;
      end
      if (wr_ch) begin
        word_reg[wr_ix]  <= hwdata[15:0];  // RULE12
        valid_reg[wr_ix] <= 1'b1;          // RULE4
      end
      if (wr_pend_reg && is_ctrl(wr_addr_reg)) begin
        run_reg <= hwdata[`OFC_CTRL_RUN];
        if (hwdata[`OFC_CTRL_RUN]) begin
          ran_reg <= 1'b1;
        end
      end
    end
  end

  // --------------------------------------------------------------
  // Output refresh and fallback
  // --------------------------------------------------------------
  reg [31:0] tick_cnt_reg;
  reg [3:0]  on_next;

  always @* begin
    for (j = 0; j < `OFC_NUM_CH; j = j + 1) begin
      if (!logic_ok) begin
        on_next[j] = 1'b0;                            // RULE6
      end else if (!valid_reg[j]) begin
        on_next[j] = 1'b0;                            // RULE3
      end else if (sel_hold[j] == `OFC_SEL_ZERO) begin
        on_next[j] = run_reg && io_ok;                // RULE5 RULE7 RULE8
      end else begin
        on_next[j] = 1'b1;                            // RULE5 RULE7
      end
    end
  end

  // Codes refresh every cycle, well inside the update period; the tick marks
  // the period so software can pace writes against it.
  // An open channel keeps its code unless logic supply is lost or no valid word was written,
  // which zeroes it; the enable cuts the current, so a kept code is of no account until driven again.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dac_code   <= 48'h0000_0000_0000;
      out_enable <= 4'h0;
    end else if (clk_en) begin
      out_enable <= on_next;
      for (k = 0; k < `OFC_NUM_CH; k = k + 1) begin
        if (on_next[k]) begin
          dac_code[k*12 +: 12] <= to_code(word_reg[k]);  // RULE4 RULE10
        end else if (!logic_ok || !valid_reg[k]) begin
          dac_code[k*12 +: 12] <= 12'h000;
        end
      end
    end
  end

  // --------------------------------------------------------------
  // Update period tick
  // --------------------------------------------------------------
  wire tick_end = (tick_cnt_reg == UPDATE_CYC - 1);

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      update_tick  <= 4'h0;
      tick_cnt_reg <= 32'h0000_0000;
    end else if (clk_en) begin
      if (tick_end) begin
        tick_cnt_reg <= 32'h0000_0000;
        update_tick  <= 4'hf;                         // RULE10
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
        update_tick  <= 4'h0;
      end
    end
  end

endmodule

// >>> core/ofc_consts.vh
// Constants for the four-channel current-output fallback control block.
// Assumes an AHB-Lite slave with 32-bit data, single word transfers only.
// Function
// RULE1 - Four independent per-channel fallback selections
// RULE2 - Left selects zero current, right holds last
// RULE3 - Power-up outputs open circuit until valid data
// RULE4 - Valid data drives output in either selection; here a zero-selected channel stays open until run_reg is set
// RULE5 - Controller stop: zero-current opens, hold keeps data
// RULE6 - Logic supply loss opens every channel
// RULE7 - IO bus supply loss: zero opens, hold keeps
// RULE8 - Zero current means 0 mA, not 4 mA
// RULE9 - Data maps linearly: 2048 is 12 mA
// RULE10 - All four channels update within 1 ms
// RULE11 - Words 4096 to 8191 are offset scale
// RULE12 - One 16-bit word latched per channel
`ifndef OFC_CONSTS_VH
`define OFC_CONSTS_VH

// --------------------------------------------------------------
// Register map (byte addresses)
// --------------------------------------------------------------
`define OFC_ADDR_CH0      12'h000
`define OFC_ADDR_CH1      12'h004
`define OFC_ADDR_CH2      12'h008
`define OFC_ADDR_CH3      12'h00c
`define OFC_ADDR_CTRL     12'h010
`define OFC_ADDR_STATUS   12'h014
`define OFC_ADDR_BITS     12
// --------------------------------------------------------------
// Fields
// --------------------------------------------------------------
`define OFC_CTRL_RUN      0
`define OFC_WORD_BITS     16
`define OFC_DAC_BITS      12
`define OFC_OFFSET_BIT    12
`define OFC_NUM_CH        4
`define OFC_WORD_RESET    16'h0000
`define OFC_SEL_ZERO      1'b0
`define OFC_HTRANS_NONSEQ 2'b10
// --------------------------------------------------------------
// Timing
// --------------------------------------------------------------
`define OFC_CLK_NS        20
`define OFC_UPDATE_NS     1000000
`define OFC_UPDATE_CYC    (`OFC_UPDATE_NS / `OFC_CLK_NS)

`endif

// >>> verification/ofc_top_asserts.sv
// Checker for the output fallback block: bus answer, fallback states, update pulse.
// Assumes it is bound into ofc_top and sees only that module's ports.
`timescale 1ns/100ps
module ofc_chk #(
  parameter UPDATE_CYC = 20
) (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        clk_en,
  input wire logic        hsel,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        logic_supply_ok,
  input wire logic        io_bus_supply_ok,
  input wire logic [31:0] haddr,
  input wire logic [31:0] hwdata,
  input wire logic [1:0]  htrans,
  input wire logic [3:0]  fallback_select_switch,
  input wire logic [3:0]  out_enable,
  input wire logic [3:0]  update_tick,
  input wire logic [47:0] dac_code
);
  logic       wv;
  logic [1:0] wch;
  logic       seen;
  int         cnt;
  // Data phase of a channel write; channel index kept for two cycles via past
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wv <= 1'b0;
      wch <= 2'h0;
      cnt <= 0;
      seen <= 1'b0;
    end else begin
      wv <= clk_en && hsel && hready && htrans == 2'h2 && hwrite && haddr[11:4] == 8'h00;
      wch <= haddr[3:2];
      // The period counter stands still with the block while clk_en is low
      if (clk_en) begin
        cnt <= update_tick[0] ? 0 : cnt + 1;
        seen <= seen | update_tick[0];
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn || !clk_en);
  chk_bus_ready: assert property (hreadyout)
    else $error("hreadyout low");
  chk_bus_okay: assert property (!hresp)
    else $error("hresp not okay");
  chk_power_off: assert property ($rose(resetn) |-> (out_enable == 4'h0) [*4])
    else $error("output on at power-up");
  chk_logic_off: assert property (!logic_supply_ok [*4] |-> out_enable == 4'h0 && dac_code == 48'h0)
    else $error("output on without logic supply");
  chk_io_zero: assert property ((logic_supply_ok && !io_bus_supply_ok
    && $stable(fallback_select_switch)) [*4] |-> (out_enable & ~fallback_select_switch) == 4'h0)
    else $error("zero channel on without io supply");
  chk_code_load: assert property (wv && logic_supply_ok |-> ##2
    (!out_enable[$past(wch, 2)] || dac_code[12*$past(wch, 2) +: 12] == $past(hwdata[11:0], 2)))
    else $error("code differs from written word");
  chk_tick_shape: assert property (update_tick != 4'h0 |-> update_tick == 4'hf ##1 update_tick == 4'h0)
    else $error("update pulse malformed");
  chk_tick_period: assert property (update_tick[0] && seen |-> cnt == UPDATE_CYC - 1)
    else $error("update pulse early");
  chk_tick_due: assert property (seen |-> cnt < UPDATE_CYC)
    else $error("update pulse late");
endmodule
bind ofc_top ofc_chk #(.UPDATE_CYC(UPDATE_CYC)) i_ofc_chk (.*);

// >>> verification/ofc_ctl.sv
// Controller model: single-word bus master that writes and reads the block.
// Assumes each task call starts just after a rising clock edge.
`timescale 1ns/100ps
module ofc_ctl (
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic             hwrite,
  output logic [1:0]       htrans,
  output logic [2:0]       hsize,
  output logic [31:0]      haddr,
  output logic [31:0]      hwdata
);
  initial begin
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] q);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= a;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
    // Released data lines must not keep the last value
    hwdata <= ~d;
  endtask
endmodule

// >>> verification/tb_top.sv
// Bench for ofc_top: random words, switches, run and IO supply states.
// Assumes the controller model and the bound checker are compiled with it.
`timescale 1ns/100ps
module tb_top;
  logic clk = 0, resetn = 0, lok = 1, iok = 1, cen = 1, run, hreadyout, hresp, hsel, hwrite;
  logic [3:0]  sw = 0, oe, tick, e;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [47:0] dac;
  logic [15:0] w [4];
  localparam logic [15:0] CW [4] = '{16'h0fff, 16'h1800, 16'h0400, 16'hffff};
  int     err_total = 0, n_compared = 0, cyc = 0, i, k;
  integer seed = 32'h8233e805;
  initial forever #10 clk = ~clk;
  ofc_top #(.UPDATE_CYC(20)) i_ofc_top (.clk(clk), .resetn(resetn), .clk_en(cen),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .fallback_select_switch(sw), .logic_supply_ok(lok),
    .io_bus_supply_ok(iok), .dac_code(dac), .out_enable(oe), .update_tick(tick));
  ofc_ctl i_ofc_ctl (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .hwrite(hwrite), .htrans(htrans), .hsize(hsize), .haddr(haddr), .hwdata(hwdata));
  task chk(input logic [47:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t seen %h expected %h", $time, got, exp);
    end
  endtask
  // Never-run zero channels count as stopped
  function logic [3:0] exp_oe(input logic [3:0] s, input logic r, l, io);
    return !l ? 4'h0 : (r && io) ? 4'hf : s;
  endfunction
  // Open channels carry no defined code, so only driven lanes are compared
  function logic [47:0] lanes(input logic [3:0] m);
    return {{12{m[3]}}, {12{m[2]}}, {12{m[1]}}, {12{m[0]}}};
  endfunction
  function logic [47:0] exp_dac(input logic l);
    return l ? {w[3][11:0], w[2][11:0], w[1][11:0], w[0][11:0]} : 48'h0;
  endfunction
  task tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    chk(oe, 4'h0);
    i_ofc_ctl.xfer(1'b1, 32'h20, 32'hffffffff, q);
    i_ofc_ctl.xfer(1'b0, 32'h20, 32'h0, q);
    chk(q, 48'h0);
    i_ofc_ctl.xfer(1'b0, 32'h0, 32'h0, q);
    chk(q, 48'h0);
    $display("reset test done");
    for (k = 0; k < 12; k++) begin
      for (i = 0; i < 4; i++) begin
        w[i] = (k == 0) ? CW[i] : $random(seed);
        i_ofc_ctl.xfer(1'b1, 4 * i, {16'h0, w[i]}, q);
      end
      run = $random(seed);
      sw <= $random(seed);
      iok <= (k < 2) | $random(seed);
      i_ofc_ctl.xfer(1'b1, 32'h10, {31'h0, run}, q);
      i_ofc_ctl.xfer(1'b0, 32'h10, 32'h0, q);
      chk(q, {31'h0, run});
      repeat (4) @(posedge clk);
      e = exp_oe(sw, run, lok, iok);
      chk(oe, e);
      chk(dac & lanes(e), exp_dac(lok) & lanes(e));
      i_ofc_ctl.xfer(1'b0, 4 * k[1:0], 32'h0, q);
      chk(q, w[k[1:0]]);
      $display("round %0d done", k);
    end
    // Supply drops while clk_en is low: outputs must stay frozen
    cen <= 1'b0;
    lok <= 1'b0;
    repeat (5) @(posedge clk);
    chk(oe, e);
    chk(dac & lanes(e), exp_dac(1'b1) & lanes(e));
    $display("clock enable freeze test done");
    cen <= 1'b1;
    iok <= 1'b0;
    repeat (5) @(posedge clk);
    chk(oe, 4'h0);
    chk(dac, 48'h0);
    $display("supply loss test done");
    tally_and_finish;
  end
endmodule
